// [rtl/universal_serial_unit.sv]
// Behaviour
// - 8-bit shift register, MSB to output pin
// - Output latch changes opposite sampling edge with external clock
// - Serial input always from data input pin
// - Readable, writable 4-bit counter with overflow
// - Register and counter share one clock source, except in strobe-count mode
// - External clock counts both edges
// - Clock from pin, timer match, software
// - Two-wire start flag and clock hold
// - SPI modes 0 and 1, no select
// - Eight clocks exchange both shift registers
// - Overflow sets the overflow flag
// - Clock pin toggles by port or strobe
// - Edge select swaps sample and shift edges
// - Sixteen external edges overflow the counter
// - Overflow flag serves as wake request
// - Flag write clears flag, loads counter
// - Toggle strobe counted in strobe-count mode
// - Half-rate master by alternating writes
// - Data write beats a simultaneous shift
`timescale 1ns/10ps
`default_nettype none
module universal_serial_unit
	import usu_pkg::*;
(
	// Clock and reset
	input  wire logic              i_clk,
	input  wire logic              i_reset,

	// Core writes to shift data register
	input  wire logic              i_data_wr,
	input  wire logic [DATA_W-1:0] i_data_wdata,

	// Core writes to control register
	input  wire logic              i_ctrl_wr,
	input  wire logic [7:0]        i_ctrl_wdata,

	// Core writes to status register
	input  wire logic              i_status_wr,
	input  wire logic [7:0]        i_status_wdata,

	// Clock pin port register and direction
	input  wire logic              i_clock_port_wr,
	input  wire logic              i_clock_port_value,
	input  wire logic              i_clock_pin_dir,

	// Timer compare match event
	input  wire logic              i_timer0_match,

	// Pins from outside
	input  wire logic              i_serial_in_pin,
	input  wire logic              i_serial_clock_pin,

	// Register views
	output logic [DATA_W-1:0]      o_shift_data_reg,
	output logic [7:0]             o_serial_control_reg,
	output logic [CNT_W-1:0]       o_counter,
	output logic                   o_counter_overflow_flag,
	output logic                   o_start_flag,

	// Pins to outside
	output logic                   o_serial_data_out,
	output logic                   o_sda_oe,
	output logic                   o_serial_clock_out,
	output logic                   o_serial_clock_oe,

	// Received bytes
	output logic                   o_rx_valid,
	output logic [DATA_W-1:0]      o_rx_data,
	input  wire logic              i_rx_ready,
	output logic                   o_rx_overrun
);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [3:0] bump(input logic [3:0] v);
		bump = v + 4'h1;
	endfunction

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	// Index 0 is the data input, index 1 the clock pin
	logic [SYNC_STAGES-1:0] sync_chain [2];
	logic [1:0]             pin_level;
	wire  [1:0]             pin_raw = {i_serial_clock_pin, i_serial_in_pin};
	wire  [1:0]             agree;
	wire  [1:0]             rise;
	wire  [1:0]             fall;

	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : g_sync
			assign agree[g] = sync_chain[g][1] == sync_chain[g][2];
			assign rise[g]  = agree[g] & sync_chain[g][2] & ~pin_level[g];
			assign fall[g]  = agree[g] & ~sync_chain[g][2] & pin_level[g];

			always_ff @(posedge i_clk or posedge i_reset)
			begin
				if (i_reset)
				begin
					sync_chain[g] <= 3'h0;
					pin_level[g]  <= 1'b0;
				end
				else
				begin
					sync_chain[g] <= {sync_chain[g][1:0], pin_raw[g]};
					if (agree[g])
						pin_level[g] <= sync_chain[g][2];
				end
			end
		end
	endgenerate

	wire serial_in_level = pin_level[0];
	wire clock_level     = pin_level[1];
	wire clock_rise      = rise[1];
	wire clock_fall      = fall[1];
	wire sda_fall        = fall[0];

	// ----------------------------------------
	// Control decode
	// ----------------------------------------
	logic [7:0] ctrl;
	// Strobes act in the very write that carries them
	wire  [7:0] eff_ctrl   = i_ctrl_wr ? i_ctrl_wdata : ctrl;
	wire  [1:0] wm_bits    = eff_ctrl[CTRL_WM_HI:CTRL_WM_LO];
	wire        cs1        = eff_ctrl[CTRL_CS1];
	wire        cs0        = eff_ctrl[CTRL_CS0];
	wire        clk_mode   = eff_ctrl[CTRL_CLK];
	wire        sw_clock   = i_ctrl_wr & i_ctrl_wdata[CTRL_CLK];
	wire        toggle_stb = i_ctrl_wr & i_ctrl_wdata[CTRL_TC];
	wire        two_wire   = wm_bits[1];
	wire        hold_mode  = wm_bits == WIRE_TWO_HOLD;

	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
			ctrl <= CTRL_RST;
		else if (i_ctrl_wr)
			ctrl <= {i_ctrl_wdata[7:1], 1'b0} | {6'h00, i_ctrl_wdata[CTRL_CLK], 1'b0};
	end

	// ----------------------------------------
	// Clock source selection
	// ----------------------------------------
	// Sample edge: rising for select 0, falling for select 1
	wire ext_sample = cs0 ? clock_fall : clock_rise;
	wire int_shift  = cs0 ? i_timer0_match : sw_clock;
	wire shift_evt  = cs1 ? ext_sample : int_shift;
	// External clock counts both edges, or the toggle strobe
	wire ext_count  = clk_mode ? toggle_stb : (clock_rise | clock_fall);
	wire count_evt  = cs1 ? ext_count : int_shift;

	// ----------------------------------------
	// Shift data register
	// ----------------------------------------
	logic [DATA_W-1:0] shift_data;
	logic [DATA_W-1:0] next_shift_data;

	always_comb
	begin
		if (i_data_wr)
			next_shift_data = i_data_wdata;
		else if (shift_evt)
			next_shift_data = {shift_data[6:0], serial_in_level};
		else
			next_shift_data = shift_data;
	end

	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
			shift_data <= DATA_RST;
		else
			shift_data <= next_shift_data;
	end

	// ----------------------------------------
	// Output latch
	// ----------------------------------------
	// Always open with an internal clock, else only in the half cycle before the shift edge,
	// so the pin moves on the edge opposite sampling
	wire  latch_open = ~cs1 | (clock_level == cs0);
	logic out_latch;
	wire  next_out   = latch_open ? shift_data[7] : out_latch;

	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			out_latch <= 1'b0;
			o_sda_oe  <= 1'b0;
		end
		else
		begin
			out_latch <= next_out;
			o_sda_oe  <= two_wire & ~next_out;
		end
	end

	// ----------------------------------------
	// Edge counter and overflow flag
	// ----------------------------------------
	logic [CNT_W-1:0] counter;
	logic             ovf_flag;
	wire              wrap      = count_evt & (counter == CNT_MAX);
	wire              ovf_clear = i_status_wr & i_status_wdata[STAT_OVF];
	wire              next_ovf  = wrap | (ovf_flag & ~ovf_clear);

	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
			counter <= CNT_RST;
		else if (i_status_wr)
			counter <= i_status_wdata[STAT_CNT_HI:STAT_CNT_LO];
		else if (count_evt)
			counter <= bump(counter);
	end

	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
			ovf_flag <= 1'b0;
		else
			ovf_flag <= next_ovf;
	end

	// ----------------------------------------
	// Two-wire start detect and wait states
	// ----------------------------------------
	logic start_flag;
	wire  start_seen  = two_wire & sda_fall & clock_level;
	wire  start_clear = i_status_wr & i_status_wdata[STAT_START];
	wire  next_start  = start_seen | (start_flag & ~start_clear);
	// Holding the clock low stretches the partner's cycle
	wire  next_hold   = two_wire & (next_start | (hold_mode & next_ovf));

	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
			start_flag <= 1'b0;
		else
			start_flag <= next_start;
	end

	// ----------------------------------------
	// Clock pin drive
	// ----------------------------------------
	logic clock_port;
	logic next_clock_port;

	always_comb
	begin
		if (i_clock_port_wr)
			next_clock_port = i_clock_port_value;
		else if (toggle_stb)
			next_clock_port = ~clock_port;
		else
			next_clock_port = clock_port;
	end

	wire next_clk_oe = two_wire
		? (next_hold | (i_clock_pin_dir & ~next_clock_port))
		: i_clock_pin_dir;
	wire next_clk_out = two_wire ? 1'b0 : next_clock_port;

	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			clock_port         <= 1'b0;
			o_serial_clock_out <= 1'b0;
			o_serial_clock_oe  <= 1'b0;
		end
		else
		begin
			clock_port         <= next_clock_port;
			o_serial_clock_out <= next_clk_out;
			o_serial_clock_oe  <= next_clk_oe;
		end
	end

	// ----------------------------------------
	// Received byte capture
	// ----------------------------------------
	// The shift register itself is unbuffered; a copy
	// goes to the pair buffer so a slow reader keeps it
	byte_stream_if push_s ();
	byte_stream_if pop_s ();

	logic              pend_valid;
	logic [DATA_W-1:0] pend_data;
	wire               pend_taken = pend_valid & push_s.ready;

	assign push_s.valid = pend_valid;
	assign push_s.data  = pend_data;
	assign pop_s.ready  = i_rx_ready;

	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			pend_valid   <= 1'b0;
			pend_data    <= DATA_RST;
			o_rx_overrun <= 1'b0;
		end
		else if (wrap)
		begin
			pend_valid <= 1'b1;
			pend_data  <= next_shift_data;
			if (pend_valid & ~push_s.ready)
				o_rx_overrun <= 1'b1;
		end
		else if (pend_taken)
			pend_valid <= 1'b0;
	end

	rx_pair_buffer u_rx_buffer (
		.i_clk   (i_clk),
		.i_reset (i_reset),
		.in_s    (push_s),
		.out_s   (pop_s)
	);

	assign o_rx_valid = pop_s.valid;
	assign o_rx_data  = pop_s.data;

	// ----------------------------------------
	// Register views
	// ----------------------------------------
	assign o_shift_data_reg        = shift_data;
	assign o_serial_control_reg    = ctrl;
	assign o_counter               = counter;
	assign o_counter_overflow_flag = ovf_flag;
	assign o_start_flag            = start_flag;
	assign o_serial_data_out       = out_latch;
endmodule // universal_serial_unit
`default_nettype wire

// [rtl/usu_pkg.sv]
`default_nettype none
package usu_pkg;
	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int DATA_W      = 8;
	localparam int CNT_W       = 4;
	localparam int SYNC_STAGES = 3;

	// ----------------------------------------
	// Control byte layout
	// ----------------------------------------
	localparam int CTRL_WM_HI = 5;
	localparam int CTRL_WM_LO = 4;
	localparam int CTRL_CS1   = 3;
	localparam int CTRL_CS0   = 2;
	localparam int CTRL_CLK   = 1;
	localparam int CTRL_TC    = 0;

	// ----------------------------------------
	// Status byte layout
	// ----------------------------------------
	localparam int STAT_START  = 7;
	localparam int STAT_OVF    = 6;
	localparam int STAT_CNT_HI = 3;
	localparam int STAT_CNT_LO = 0;

	// ----------------------------------------
	// Reset values and limits
	// ----------------------------------------
	localparam logic [7:0] DATA_RST = 8'h00;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [3:0] CNT_RST  = 4'h0;
	localparam logic [3:0] CNT_MAX  = 4'hf;

	typedef enum logic [1:0] {
		WIRE_NONE     = 2'h0,
		WIRE_THREE    = 2'h1,
		WIRE_TWO      = 2'h2,
		WIRE_TWO_HOLD = 2'h3
	} wire_mode_e;
endpackage
`default_nettype wire

// [rtl/byte_stream_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface byte_stream_if;
	logic       valid;
	logic       ready;
	logic [7:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// [rtl/rx_pair_buffer.sv]
`timescale 1ns/10ps
`default_nettype none
module rx_pair_buffer
	import usu_pkg::*;
(
	// Clock and reset
	input  wire logic     i_clk,
	input  wire logic     i_reset,
	// Stream sides
	byte_stream_if.snk    in_s,
	byte_stream_if.src    out_s
);
	// ----------------------------------------
	// Head and skid entry
	// ----------------------------------------
	logic              head_valid;
	logic [DATA_W-1:0] head_data;
	logic              tail_valid;
	logic [DATA_W-1:0] tail_data;
	wire               push = in_s.valid & ~tail_valid;
	wire               head_free = ~head_valid | out_s.ready;

	// Skid entry full means the source must wait
	assign in_s.ready  = ~tail_valid;
	assign out_s.valid = head_valid;
	assign out_s.data  = head_data;

	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			head_valid <= 1'b0;
			head_data  <= DATA_RST;
			tail_valid <= 1'b0;
			tail_data  <= DATA_RST;
		end
		else if (head_free)
		begin
			head_valid <= tail_valid | push;
			head_data  <= tail_valid ? tail_data : in_s.data;
			tail_valid <= tail_valid & push;
			if (tail_valid & push)
				tail_data <= in_s.data;
		end
		else if (push)
		begin
			tail_valid <= 1'b1;
			tail_data  <= in_s.data;
		end
	end
endmodule // rx_pair_buffer
`default_nettype wire

// [tb/usu_assertions.sv]
`timescale 1ns/10ps
`default_nettype none
module usu_assertions
(
	// Clock, reset and core side
	input wire logic       i_clk,
	input wire logic       i_reset,
	input wire logic       i_data_wr,
	input wire logic [7:0] i_data_wdata,
	input wire logic       i_ctrl_wr,
	input wire logic [7:0] i_ctrl_wdata,
	input wire logic       i_status_wr,
	input wire logic [7:0] i_status_wdata,
	input wire logic       i_clock_port_wr,
	input wire logic       i_rx_ready,
	// Watched outputs
	input wire logic [7:0] o_shift_data_reg,
	input wire logic [7:0] o_serial_control_reg,
	input wire logic [3:0] o_counter,
	input wire logic       o_counter_overflow_flag,
	input wire logic       o_serial_data_out,
	input wire logic       o_serial_clock_out,
	input wire logic       o_rx_valid,
	input wire logic [7:0] o_rx_data
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_reset);

	// ----------------------------------------
	// Steps of a transfer
	// ----------------------------------------
	sequence s_top;
		o_counter == 4'hf && !i_status_wr;
	endsequence
	sequence s_strobe;
		i_ctrl_wr && i_ctrl_wdata[5:1] == 5'h09 && !i_data_wr && !i_status_wr;
	endsequence

	chk_write_wins:
	assert property (i_data_wr |=> o_shift_data_reg == $past(i_data_wdata))
	else $error("shift data not taken from core write");
	chk_count_load:
	assert property (i_status_wr |=> o_counter == $past(i_status_wdata[3:0]))
	else $error("counter not loaded by status write");
	chk_flag_clear:
	assert property (i_status_wr && i_status_wdata[6] && o_counter != 4'hf
		|=> !o_counter_overflow_flag)
	else $error("overflow flag not cleared");
	chk_wrap_flag:
	assert property (s_top ##1 o_counter == 4'h0 |-> o_counter_overflow_flag)
	else $error("wrap without overflow flag");
	chk_sw_strobe:
	assert property (s_strobe |=> o_counter == $past(o_counter) + 4'h1
		&& o_shift_data_reg[7:1] == $past(o_shift_data_reg[6:0]))
	else $error("strobe did not shift and count together");
	chk_toggle_pin:
	assert property (i_ctrl_wr && i_ctrl_wdata[0] && !i_clock_port_wr
		&& i_ctrl_wdata[5:4] == 2'h1 && o_serial_control_reg[5:4] == 2'h1
		|=> o_serial_clock_out != $past(o_serial_clock_out))
	else $error("toggle strobe left clock pin");
	chk_latch_open:
	assert property (o_serial_control_reg[5:3] == 3'h2 && !i_ctrl_wr
		|=> o_serial_data_out == $past(o_shift_data_reg[7]))
	else $error("open latch did not follow top bit");
	chk_rx_hold:
	assert property (o_rx_valid && !i_rx_ready
		|=> o_rx_valid && $stable(o_rx_data))
	else $error("receive head dropped while stalled");
endmodule // usu_assertions

bind universal_serial_unit usu_assertions u_chk (
	.i_clk, .i_reset, .i_data_wr, .i_data_wdata, .i_ctrl_wr, .i_ctrl_wdata,
	.i_status_wr, .i_status_wdata, .i_clock_port_wr, .i_rx_ready,
	.o_shift_data_reg, .o_serial_control_reg, .o_counter,
	.o_counter_overflow_flag, .o_serial_data_out, .o_serial_clock_out,
	.o_rx_valid, .o_rx_data);
`default_nettype wire

// [tb/spi_far_master.sv]
`timescale 1ns/10ps
`default_nettype none
module spi_far_master
(
	// Bench control
	input  wire logic       i_go,
	input  wire logic       i_mode,
	input  wire logic       i_slow,
	input  wire logic [7:0] i_tx,
	// Serial lines
	input  wire logic       i_miso,
	output logic            o_sclk,
	output logic            o_mosi,
	// Results
	output logic [7:0]      o_rx,
	output logic            o_done
);
	realtime half;

	initial
	begin
		o_sclk = 1'b0;
		o_mosi = 1'b0;
		o_rx = 8'h00;
		o_done = 1'b0;
	end

	// Clock stands low between frames; edges kept off the
	// core clock's edges so a pin never races the sampler
	always @(posedge i_go)
	begin
		o_done = 1'b0;
		half = 62.5;
		#1;
		// Slow start: longer lead-in, same link period
		if (i_slow)
			#250;
		for (int i = 7; i >= 0; i--)
		begin
			if (!i_mode) o_mosi = i_tx[i];
			#half;
			o_sclk = 1'b1;
			if (i_mode) o_mosi = i_tx[i];
			else o_rx = {o_rx[6:0], i_miso};
			#half;
			o_sclk = 1'b0;
			if (i_mode) o_rx = {o_rx[6:0], i_miso};
		end
		// Released line must not keep showing the last bit
		#half;
		o_mosi = ~o_mosi;
		o_done = 1'b1;
	end
endmodule // spi_far_master
`default_nettype wire

// [tb/universal_serial_three_wire_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module universal_serial_three_wire_tb_top
	import usu_pkg::*;
();
	logic i_clk = 1'b0, i_reset = 1'b1, i_clock_pin_dir = 1'b0;
	logic i_data_wr = 1'b0, i_ctrl_wr = 1'b0, i_status_wr = 1'b0;
	logic i_clock_port_wr = 1'b0, i_rx_ready = 1'b0;
	logic [7:0] wd = 8'h00, p_tx = 8'h00;
	logic p_go = 1'b0, p_mode = 1'b0, p_slow = 1'b0, tmr = 1'b0;
	logic [7:0] o_shift_data_reg, o_serial_control_reg, o_rx_data, p_rx;
	logic [3:0] o_counter;
	logic o_counter_overflow_flag, o_serial_data_out, o_serial_clock_out;
	logic o_serial_clock_oe, o_rx_valid, o_rx_overrun, p_sclk, p_mosi;
	logic p_done, o_start_flag, o_sda_oe;
	int failures = 0, check_count = 0;
	wire logic sck_w = o_serial_clock_oe ? o_serial_clock_out : p_sclk;

	always #5 i_clk = ~i_clk;

	universal_serial_unit dut (
		.i_clk, .i_reset, .i_data_wr, .i_data_wdata(wd), .i_ctrl_wr,
		.i_ctrl_wdata(wd), .i_status_wr, .i_status_wdata(wd),
		.i_clock_port_wr, .i_clock_port_value(wd[0]), .i_clock_pin_dir,
		.i_timer0_match(tmr), .i_serial_in_pin(p_mosi),
		.i_serial_clock_pin(sck_w), .o_shift_data_reg, .o_serial_control_reg,
		.o_counter, .o_counter_overflow_flag, .o_start_flag,
		.o_serial_data_out, .o_sda_oe, .o_serial_clock_out,
		.o_serial_clock_oe, .o_rx_valid, .o_rx_data, .i_rx_ready,
		.o_rx_overrun);

	spi_far_master far (.i_go(p_go), .i_mode(p_mode), .i_slow(p_slow),
		.i_tx(p_tx), .i_miso(o_serial_data_out), .o_sclk(p_sclk),
		.o_mosi(p_mosi), .o_rx(p_rx), .o_done(p_done));

	// ----------------------------------------
	// Shared helpers
	// ----------------------------------------
	task close_out;
		$display("Comparisons %0d, mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp)
		begin
			failures++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// One write pulse: 0 data, 1 control, 2 status, 3 port, else none
	task core_wr(input int k, input logic [7:0] v);
		@(negedge i_clk);
		i_data_wr = (k == 0);
		i_ctrl_wr = (k == 1);
		i_status_wr = (k == 2);
		i_clock_port_wr = (k == 3);
		wd = v;
	endtask

	// 0 far side done, 1 overflow flag, 2 receive head valid
	task automatic wait_hi(input int sel);
		int n;
		n = 0;
		while ((sel == 0 ? p_done : sel == 1 ? o_counter_overflow_flag
			: o_rx_valid) !== 1'b1)
		begin
			@(negedge i_clk);
			n++;
			if (n > 4000)
			begin
				failures++;
				close_out();
			end
		end
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task ext_xfer(input logic cs0, input logic [7:0] d, input logic [7:0] m);
		core_wr(2, 8'h40);
		core_wr(1, {5'h03, cs0, 2'h0});
		core_wr(0, d);
		core_wr(4, 8'h00);
		repeat (3) @(negedge i_clk);
		p_mode = cs0;
		p_tx = m;
		p_go = 1'b1;
		@(negedge i_clk);
		wait_hi(0);
		p_go = 1'b0;
		wait_hi(1);
		chk(o_shift_data_reg, m);
		chk(p_rx, d);
		chk({4'h0, o_counter}, 8'h00);
	endtask

	task strobes(input logic [7:0] a, input logic [7:0] b, input int gap,
		input logic [3:0] ecnt, input logic eflag);
		logic bin;
		bin = p_mosi;
		i_clock_pin_dir = 1'b1;
		core_wr(3, 8'h00);
		core_wr(2, 8'h40);
		core_wr(0, 8'h00);
		for (int i = 0; i < 16; i++)
		begin
			core_wr(1, i[0] ? b : a);
			if (gap > 0)
			begin
				core_wr(4, 8'h00);
				repeat (gap) @(negedge i_clk);
			end
		end
		core_wr(4, 8'h00);
		repeat (8) @(negedge i_clk);
		chk({4'h0, o_counter}, {4'h0, ecnt});
		chk({7'h0, o_counter_overflow_flag}, {7'h0, eflag});
		chk(o_shift_data_reg, {8{bin}});
		chk({7'h0, o_serial_clock_out}, 8'h00);
		i_clock_pin_dir = 1'b0;
	endtask

	task drain;
		logic [7:0] exp [3];
		exp = '{8'h3c, 8'hc2, 8'h81};
		for (int k = 0; k < 3; k++)
		begin
			wait_hi(2);
			chk(o_rx_data, exp[k]);
			i_rx_ready = 1'b1;
			@(negedge i_clk);
			i_rx_ready = 1'b0;
			@(negedge i_clk);
		end
		repeat (3) @(negedge i_clk);
		chk({7'h0, o_rx_valid}, 8'h00);
	endtask

	// Timer-clocked shifting, then two-wire data drive
	task side_modes;
		logic bin;
		bin = p_mosi;
		core_wr(2, 8'h40);
		core_wr(1, 8'h14);
		core_wr(0, 8'h00);
		core_wr(4, 8'h00);
		tmr = 1'b1;
		repeat (3) @(negedge i_clk);
		tmr = 1'b0;
		@(negedge i_clk);
		chk({4'h0, o_counter}, 8'h03);
		chk(o_shift_data_reg, {5'h00, {3{bin}}});
		core_wr(1, 8'h20);
		core_wr(0, 8'h7f);
		core_wr(4, 8'h00);
		repeat (2) @(negedge i_clk);
		chk({6'h0, o_sda_oe, o_serial_data_out}, 8'h02);
		chk({6'h0, o_start_flag, o_serial_clock_oe}, 8'h00);
		core_wr(0, 8'h80);
		core_wr(4, 8'h00);
		repeat (2) @(negedge i_clk);
		chk({6'h0, o_sda_oe, o_serial_data_out}, 8'h01);
	endtask

	task reset_check;
		i_reset = 1'b1;
		repeat (4) @(negedge i_clk);
		i_reset = 1'b0;
		@(negedge i_clk);
		chk(o_shift_data_reg, DATA_RST);
		chk(o_serial_control_reg, CTRL_RST);
		chk({4'h0, o_counter}, {4'h0, CNT_RST});
		chk({7'h0, o_rx_overrun}, 8'h00);
	endtask

	initial
	begin
		repeat (4) @(negedge i_clk);
		i_reset = 1'b0;
		ext_xfer(1'b0, 8'ha5, 8'h3c);
		ext_xfer(1'b1, 8'h5a, 8'hc2);
		strobes(8'h11, 8'h13, 0, 4'h8, 1'b0);
		strobes(8'h1b, 8'h1b, 6, 4'h0, 1'b1);
		chk({7'h0, o_rx_overrun}, 8'h00);
		p_slow = 1'b1;
		ext_xfer(1'b0, 8'h96, 8'h81);
		chk({7'h0, o_rx_overrun}, 8'h01);
		drain();
		side_modes();
		reset_check();
		close_out();
	end
endmodule // universal_serial_three_wire_tb_top
`default_nettype wire
